// ==== vrc_pkg.sv ====
package vrc_pkg;

  // ---------------------------------------------------------------------------
  // Serial word layout
  // ---------------------------------------------------------------------------
  localparam int CMD_BITS      = 16;
  localparam int ADDR_BITS     = 10;
  localparam int STAT_BITS     = 12;
  localparam int CNT_BITS      = 5;
  localparam int CMD_CUE_POS   = 11;
  localparam int CMD_IAB_POS   = 12;
  localparam int CMD_WAKE_POS  = 13;
  localparam int CMD_DIR_POS   = 14;
  localparam int CMD_RUN_POS   = 15;
  localparam int STAT_OVF_POS  = 0;
  localparam int STAT_EOM_POS  = 1;
  localparam int STAT_PTR_POS  = 2;

  // ---------------------------------------------------------------------------
  // Memory geometry and reset values
  // ---------------------------------------------------------------------------
  localparam logic [9:0]  ROW_LAST      = 10'h257;
  localparam logic [9:0]  ROW_RESET     = 10'h000;
  localparam logic [15:0] CMD_RESET     = 16'h0000;
  localparam logic [31:0] TIMER_RESET   = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int SAMPLE_HZ     = 8000;
  localparam int ROW_CELLS     = 1600;
  localparam int CUE_SPEEDUP   = 1600;
  localparam int WAKE_DELAY_MS = 25;
  localparam int WAKE_CYC      = WAKE_DELAY_MS * (CLK_HZ / 1000);
  localparam int ROW_PLAY_CYC  = ROW_CELLS * (CLK_HZ / SAMPLE_HZ);
  localparam int ROW_CUE_CYC   = ROW_PLAY_CYC / CUE_SPEEDUP;

  typedef enum logic [1:0] {
    VRC_IDLE = 2'b00,
    VRC_PLAY = 2'b01,
    VRC_REC  = 2'b10,
    VRC_CUE  = 2'b11
  } vrc_op_e;

endpackage

// ==== vrc_link_if.sv ====
`timescale 1ns/1ps
interface vrc_link_if;
  logic [15:0] cmd_word;
  logic        cmd_full;
  logic [11:0] stat_word;

  modport link (output cmd_word, output cmd_full, input stat_word);
  modport core (input cmd_word, input cmd_full, output stat_word);
endinterface

// ==== vrc_spi_link.sv ====
`timescale 1ns/1ps
module vrc_spi_link (
  // Serial pins
  input  wire logic i_sclk,
  input  wire logic i_ss_n,
  input  wire logic i_mosi,
  output logic      o_miso,
  // Core side
  input  wire logic i_rstn,
  vrc_link_if.link  lnk
);

  logic [4:0]  bit_cnt_reg;
  logic [3:0]  out_cnt_reg;
  logic [15:0] shift_reg;
  logic [15:0] cmd_reg;
  logic        full_reg;
  logic        miso_reg;

  // ---------------------------------------------------------------------------
  // Receive
  // ---------------------------------------------------------------------------
  // Slave select high ends the frame even though the clock has stopped
  always_ff @(posedge i_sclk or posedge i_ss_n) begin
    if (i_ss_n) begin
      bit_cnt_reg <= 5'h00;
    end else if (bit_cnt_reg != 5'h10) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge i_sclk or posedge i_ss_n) begin
    if (i_ss_n) begin
      shift_reg <= vrc_pkg::CMD_RESET;
    end else begin
      shift_reg <= {i_mosi, shift_reg[15:1]};
    end
  end

  always_ff @(posedge i_sclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmd_reg  <= vrc_pkg::CMD_RESET;
      full_reg <= 1'b0;
    end else if (bit_cnt_reg == 5'h0f) begin
      cmd_reg  <= {i_mosi, shift_reg[15:1]};
      full_reg <= 1'b1;
    end else if (bit_cnt_reg == 5'h00) begin
      full_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit
  // ---------------------------------------------------------------------------
  // falling edge drive
  always_ff @(negedge i_sclk or posedge i_ss_n) begin
    if (i_ss_n) begin
      out_cnt_reg <= 4'h0;
      miso_reg    <= 1'b0;
    end else begin
      miso_reg    <= (out_cnt_reg < 4'hc) ? lnk.stat_word[out_cnt_reg] : 1'b0;
      out_cnt_reg <= out_cnt_reg + {3'h0, (out_cnt_reg != 4'hf)};
    end
  end

  assign lnk.cmd_word = cmd_reg;
  assign lnk.cmd_full = full_reg;
  assign o_miso       = miso_reg;

endmodule

// ==== vrc_voice_ctrl.sv ====
`timescale 1ns/1ps
module vrc_voice_ctrl #(
  parameter int WAKE_CYC     = vrc_pkg::WAKE_CYC,
  parameter int ROW_PLAY_CYC = vrc_pkg::ROW_PLAY_CYC,
  parameter int ROW_CUE_CYC  = vrc_pkg::ROW_CUE_CYC
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  // Serial link
  input  wire logic i_sclk,
  input  wire logic i_ss_n,
  input  wire logic i_mosi,
  output logic      o_miso,
  output logic      o_miso_oe,
  // Flash array
  input  wire logic i_row_eom,
  output logic      o_row_clock_out,
  output logic [9:0] o_row_addr,
  // Status
  output logic      o_int_n,
  output logic      o_wake,
  output logic      o_ready,
  output logic      o_play,
  output logic      o_record
);

  function automatic logic is_last(input logic [9:0] row);
    is_last = (row == vrc_pkg::ROW_LAST);
  endfunction

  vrc_link_if lnk ();

  vrc_spi_link u_link (
    .i_sclk (i_sclk),
    .i_ss_n (i_ss_n),
    .i_mosi (i_mosi),
    .o_miso (o_miso),
    .i_rstn (i_rstn),
    .lnk    (lnk)
  );

  logic            ss_s1_reg;
  logic            ss_s2_reg;
  logic            ss_s3_reg;
  logic            ss_s4_reg;
  logic            full_s1_reg;
  logic            full_s2_reg;
  logic            take_cmd;
  logic            ss_fall;
  logic [9:0]      cmd_addr;
  logic            cmd_cue;
  logic            cmd_iab;
  logic            cmd_wake;
  logic            cmd_dir;
  logic            cmd_run;
  vrc_pkg::vrc_op_e op_reg;
  logic            wake_reg;
  logic            ready_reg;
  logic [31:0]     wake_cnt_reg;
  logic [31:0]     row_cnt_reg;
  logic            row_end;
  logic [9:0]      row_ptr_reg;
  logic            iab_reg;
  logic            ovf_reg;
  logic            eom_reg;
  logic            ovf_set;
  logic            eom_set;
  logic [11:0]     stat_reg;
  logic            oe_reg;
  logic            int_n_reg;
  logic            rac_reg;
  logic            start_ok;
  logic            keep_row;

  // ---------------------------------------------------------------------------
  // Crossing from the serial clock
  // ---------------------------------------------------------------------------
  // The command word is held still between frames; only the full flag and
  // slave select are synchronised, and the word is read once both settled.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ss_s1_reg   <= 1'b1;
      ss_s2_reg   <= 1'b1;
      ss_s3_reg   <= 1'b1;
      ss_s4_reg   <= 1'b1;
      full_s1_reg <= 1'b0;
      full_s2_reg <= 1'b0;
    end else begin
      ss_s1_reg   <= i_ss_n;
      ss_s2_reg   <= ss_s1_reg;
      ss_s3_reg   <= ss_s2_reg;
      ss_s4_reg   <= ss_s3_reg;
      full_s1_reg <= lnk.cmd_full;
      full_s2_reg <= full_s1_reg;
    end
  end

  assign take_cmd = ss_s3_reg & ~ss_s4_reg & full_s2_reg;
  assign ss_fall  = ~ss_s3_reg & ss_s4_reg;

  assign cmd_addr = lnk.cmd_word[9:0];
  assign cmd_cue  = lnk.cmd_word[vrc_pkg::CMD_CUE_POS];
  assign cmd_iab  = lnk.cmd_word[vrc_pkg::CMD_IAB_POS];
  assign cmd_wake = lnk.cmd_word[vrc_pkg::CMD_WAKE_POS];
  assign cmd_dir  = lnk.cmd_word[vrc_pkg::CMD_DIR_POS];
  assign cmd_run  = lnk.cmd_word[vrc_pkg::CMD_RUN_POS];

  assign start_ok = take_cmd & cmd_wake & cmd_run & ready_reg;
  // A repeated start with address ignore keeps the row in progress
  assign keep_row = start_ok & cmd_iab & (op_reg != vrc_pkg::VRC_IDLE);

  // ---------------------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------------------
  // wake bit control
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      wake_reg <= 1'b0;
    end else if (take_cmd) begin
      wake_reg <= cmd_wake;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      wake_cnt_reg <= vrc_pkg::TIMER_RESET;
      ready_reg    <= 1'b0;
    end else if (take_cmd && !cmd_wake) begin
      wake_cnt_reg <= vrc_pkg::TIMER_RESET;
      ready_reg    <= 1'b0;
    end else if (take_cmd && !wake_reg) begin
      wake_cnt_reg <= vrc_pkg::TIMER_RESET;
    end else if (wake_reg && !ready_reg) begin
      if (wake_cnt_reg == 32'(WAKE_CYC - 1)) begin
        ready_reg <= 1'b1;
      end else begin
        wake_cnt_reg <= wake_cnt_reg + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Row timing
  // ---------------------------------------------------------------------------
  // row period, shortened in cue
  assign row_end = (op_reg != vrc_pkg::VRC_IDLE) &&
                   (row_cnt_reg == ((op_reg == vrc_pkg::VRC_CUE) ?
                                    32'(ROW_CUE_CYC - 1) : 32'(ROW_PLAY_CYC - 1)));

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      row_cnt_reg <= vrc_pkg::TIMER_RESET;
    end else if ((start_ok && !keep_row) || row_end) begin
      row_cnt_reg <= vrc_pkg::TIMER_RESET;
    end else if (op_reg != vrc_pkg::VRC_IDLE) begin
      row_cnt_reg <= row_cnt_reg + 32'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Operation state
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      op_reg <= vrc_pkg::VRC_IDLE;
    end else if (take_cmd && (!cmd_wake || !cmd_run)) begin
      op_reg <= vrc_pkg::VRC_IDLE;
    end else if (start_ok) begin
      if (cmd_cue) begin
        op_reg <= vrc_pkg::VRC_CUE;
      end else if (cmd_dir) begin
        op_reg <= vrc_pkg::VRC_PLAY;
      end else begin
        op_reg <= vrc_pkg::VRC_REC;
      end
    end else if (row_end) begin
      case (op_reg)
        vrc_pkg::VRC_PLAY, vrc_pkg::VRC_CUE: begin
          if (i_row_eom || is_last(row_ptr_reg)) begin
            op_reg <= vrc_pkg::VRC_IDLE;
          end
        end
        vrc_pkg::VRC_REC: begin
          if (is_last(row_ptr_reg)) begin
            op_reg <= vrc_pkg::VRC_IDLE;
          end
        end
        default: op_reg <= vrc_pkg::VRC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      iab_reg <= 1'b0;
    end else if (take_cmd) begin
      iab_reg <= cmd_iab;
    end
  end

  // ---------------------------------------------------------------------------
  // Row pointer
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      row_ptr_reg <= vrc_pkg::ROW_RESET;
    end else if (start_ok && !cmd_iab) begin
      row_ptr_reg <= cmd_addr;
    end else if (row_end && !is_last(row_ptr_reg)) begin
      if (op_reg == vrc_pkg::VRC_CUE) begin
        row_ptr_reg <= row_ptr_reg + 10'h001;
      end else if (iab_reg && !(op_reg == vrc_pkg::VRC_PLAY && i_row_eom)) begin
        row_ptr_reg <= row_ptr_reg + 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Flags and status word
  // ---------------------------------------------------------------------------
  // overflow at last row, except play or cue ending at the end marker
  assign ovf_set = row_end && is_last(row_ptr_reg) &&
                   !(op_reg != vrc_pkg::VRC_REC && i_row_eom);
  assign eom_set = row_end && i_row_eom && (op_reg != vrc_pkg::VRC_REC);

  // cleared at frame start, an event in that cycle wins
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ovf_reg <= 1'b0;
      eom_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_set | (ovf_reg & ~ss_fall);
      eom_reg <= eom_set | (eom_reg & ~ss_fall);
    end
  end

  // The snapshot freezes for the whole frame, so the serial side reads a
  // word that cannot change under it.
  // status snapshot
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      stat_reg <= 12'h000;
    end else if (ss_s2_reg && ss_s3_reg) begin
      stat_reg <= {row_ptr_reg, eom_reg, ovf_reg};
    end
  end

  assign lnk.stat_word = stat_reg;

  // ---------------------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      oe_reg    <= 1'b0;
      int_n_reg <= 1'b1;
      rac_reg   <= 1'b0;
    end else begin
      oe_reg    <= ~ss_s2_reg;
      int_n_reg <= ~(ovf_set | eom_set | ((ovf_reg | eom_reg) & ~ss_fall));
      rac_reg   <= row_end;
    end
  end

  assign o_miso_oe       = oe_reg;
  assign o_int_n         = int_n_reg;
  assign o_row_clock_out = rac_reg;
  assign o_row_addr      = row_ptr_reg;
  assign o_wake          = wake_reg;
  assign o_ready         = ready_reg;
  assign o_play          = op_reg[0];
  assign o_record        = op_reg[1] & ~op_reg[0];

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_start_cmd;
    take_cmd && cmd_wake && cmd_run && ready_reg;
  endsequence
  sequence s_end_row_eom;
    row_end && i_row_eom && (op_reg == vrc_pkg::VRC_PLAY);
  endsequence
  property p_not_ready;
    @(posedge i_mclk) disable iff (!i_rstn)
      take_cmd && cmd_run && !ready_reg && op_reg == vrc_pkg::VRC_IDLE
      |=> op_reg == vrc_pkg::VRC_IDLE;
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("start before ready");
  property p_start_at_select;
    @(posedge i_mclk) disable iff (!i_rstn)
      $changed(op_reg) && op_reg != vrc_pkg::VRC_IDLE |-> $past(take_cmd);
  endproperty
  a_start_at_select: assert property (p_start_at_select) else $error("start w/o select rise");
  property p_addr_load;
    @(posedge i_mclk) disable iff (!i_rstn)
      s_start_cmd ##0 !cmd_iab |=> row_ptr_reg == $past(cmd_addr);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("row not loaded");
  property p_addr_keep;
    @(posedge i_mclk) disable iff (!i_rstn)
      s_start_cmd ##0 cmd_iab ##0 !row_end |=> $stable(row_ptr_reg);
  endproperty
  a_addr_keep: assert property (p_addr_keep) else $error("row moved on ignore");
  property p_power_down;
    @(posedge i_mclk) disable iff (!i_rstn)
      take_cmd && !cmd_wake |=> !wake_reg && !ready_reg && op_reg == vrc_pkg::VRC_IDLE;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down ignored");
  property p_play_dir;
    @(posedge i_mclk) disable iff (!i_rstn)
      s_start_cmd ##0 !cmd_cue ##0 cmd_dir |=> o_play && !o_record;
  endproperty
  a_play_dir: assert property (p_play_dir) else $error("wrong direction");
  property p_eom_stop;
    @(posedge i_mclk) disable iff (!i_rstn)
      s_end_row_eom ##0 !take_cmd |=> op_reg == vrc_pkg::VRC_IDLE && eom_reg && !o_int_n;
  endproperty
  a_eom_stop: assert property (p_eom_stop) else $error("no stop at end marker");
  property p_rec_ovf;
    @(posedge i_mclk) disable iff (!i_rstn)
      row_end && op_reg == vrc_pkg::VRC_REC && is_last(row_ptr_reg) && !take_cmd
      |=> ovf_reg && op_reg == vrc_pkg::VRC_IDLE;
  endproperty
  a_rec_ovf: assert property (p_rec_ovf) else $error("record ran past end");
  property p_int_clear;
    @(posedge i_mclk) disable iff (!i_rstn)
      ss_fall && !row_end |=> !ovf_reg && !eom_reg && o_int_n;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("flags not cleared");

endmodule

// ==== vrc_host_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Host side: serial master, mode 0, clock only within frames
// ---------------------------------------------------------------------------
module vrc_host_model (
  // Serial pins
  output logic      o_sclk,
  output logic      o_ss_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  initial begin
    o_sclk = 1'b0;
    o_ss_n = 1'b0;
    o_mosi = 1'b0;
    // Brief low select so the link counters see a clearing edge at start
    #1;
    o_ss_n = 1'b1;
  end

  task automatic xfer(input logic [15:0] cmd, output logic [11:0] stat);
    logic [15:0] got;
    got = 16'h0000;
    // Odd gap keeps the link phase apart from the core clock
    #113;
    o_ss_n = 1'b0;
    for (int k = 0; k < 16; k++) begin
      o_mosi = cmd[k];
      #80;
      o_sclk = 1'b1;
      // Status bit k arrives on the fall before rise k+1
      if (k > 0) got[k-1] = i_miso;
      #80;
      o_sclk = 1'b0;
    end
    #80;
    o_ss_n = 1'b1;
    // Released line must not look like the last bit
    o_mosi = ~o_mosi;
    stat = got[11:0];
  endtask
endmodule

// ==== voice_recorder_command_control_bench.sv ====
`timescale 1ns/1ps
module voice_recorder_command_control_bench;
  // ---------------------------------------------------------------------------
  // Shortened counts
  // ---------------------------------------------------------------------------
  localparam logic [11:0] WAKE = 12'h014;
  localparam logic [11:0] PLAY = 12'h040;
  localparam logic [11:0] CUE  = 12'h004;
  localparam logic [9:0]  LAST = vrc_pkg::ROW_LAST;

  logic        i_mclk;
  logic        i_rstn;
  logic        i_sclk;
  logic        i_ss_n;
  logic        i_mosi;
  logic        i_row_eom;
  logic        o_miso;
  logic        o_miso_oe;
  logic        o_row_clock_out;
  logic [9:0]  o_row_addr;
  logic        o_int_n;
  logic        o_wake;
  logic        o_ready;
  logic        o_play;
  logic        o_record;
  logic [11:0] st;
  logic [11:0] n;
  logic [9:0]  p;
  int          n_fail;
  int          samples_checked;
  int          cycles;
  // Undriven pin floats so a missing enable shows as a mismatch
  wire         miso_pin = o_miso_oe ? o_miso : 1'bz;

  vrc_voice_ctrl #(.WAKE_CYC(WAKE), .ROW_PLAY_CYC(PLAY), .ROW_CUE_CYC(CUE)) dut_u (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_sclk(i_sclk), .i_ss_n(i_ss_n), .i_mosi(i_mosi),
    .o_miso(o_miso), .o_miso_oe(o_miso_oe), .i_row_eom(i_row_eom),
    .o_row_clock_out(o_row_clock_out), .o_row_addr(o_row_addr), .o_int_n(o_int_n),
    .o_wake(o_wake), .o_ready(o_ready), .o_play(o_play), .o_record(o_record));

  vrc_host_model host_u (.o_sclk(i_sclk), .o_ss_n(i_ss_n), .o_mosi(i_mosi), .i_miso(miso_pin));

  always #5 i_mclk = ~i_mclk;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] mk(input logic run, dir, address_ignore_flag, cue, input logic [9:0] a);
    return {run, dir, 1'b1, address_ignore_flag, cue, 1'b0, a};
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge i_mclk);
  endtask

  task automatic send(input logic [15:0] cmd);
    host_u.xfer(cmd, st);
    tick(8);
  endtask

  // Cycles until the next row pulse, bounded
  task automatic wait_row(output logic [11:0] cnt);
    cnt = 12'h000;
    do begin
      @(negedge i_mclk);
      cnt++;
    end while (o_row_clock_out !== 1'b1 && cnt < 12'h12c);
    if (cnt >= 12'h12c) begin
      n_fail++;
      $display("ERROR t=%0t row pulse missing got=%h exp=%h", $time, cnt, PLAY);
    end
  endtask

  task automatic done(input string name);
    $display("%s done, failures %0d", name, n_fail);
  endtask

  task automatic close_out();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk({o_wake, o_ready, o_play, o_record, o_int_n, o_row_clock_out}, 12'h002);
    chk({o_miso_oe, o_miso}, 12'h000);
    chk(o_row_addr, 12'h000);
    done("reset");
  endtask

  task automatic t_wake();
    send(16'h2000);
    chk({o_wake, o_ready}, 12'h002);
    tick(WAKE);
    chk({o_wake, o_ready}, 12'h003);
    send(16'h2000);
    tick(2 * WAKE);
    chk(o_ready, 12'h001);
    done("wake");
  endtask

  task automatic t_play();
    host_u.xfer(mk(1'b1, 1'b1, 1'b0, 1'b0, 10'h005), st);
    chk(o_play, 12'h000);
    tick(8);
    chk({o_play, o_record}, 12'h002);
    chk(o_row_addr, 12'h005);
    wait_row(n);
    wait_row(n);
    chk(n, PLAY);
    chk(o_row_addr, 12'h005);
    send(mk(1'b1, 1'b1, 1'b1, 1'b0, 10'h3ff));
    wait_row(n);
    if (o_row_addr === 10'h005) wait_row(n);
    chk(o_row_addr, 12'h006);
    done("play");
  endtask

  task automatic t_eom();
    i_row_eom = 1'b1;
    wait_row(n);
    tick(2);
    chk({o_play, o_int_n}, 12'h000);
    tick(PLAY);
    chk({o_play, o_row_addr}, 12'h006);
    i_row_eom = 1'b0;
    host_u.xfer(mk(1'b0, 1'b0, 1'b1, 1'b0, 10'h000), st);
    chk(st, {10'h006, 2'b10});
    chk(o_int_n, 12'h001);
    tick(100);
    done("eom");
  endtask

  task automatic t_rec();
    i_row_eom = 1'b1;
    send(mk(1'b1, 1'b0, 1'b0, 1'b0, LAST));
    chk({o_play, o_record}, 12'h001);
    wait_row(n);
    tick(2);
    chk({o_record, o_int_n}, 12'h000);
    i_row_eom = 1'b0;
    send(mk(1'b0, 1'b0, 1'b1, 1'b0, 10'h000));
    chk(st, {LAST, 2'b01});
    done("record");
  endtask

  task automatic t_cue();
    send(mk(1'b1, 1'b1, 1'b0, 1'b1, 10'h010));
    wait_row(n);
    wait_row(n);
    chk(n, CUE);
    p = o_row_addr;
    i_row_eom = 1'b1;
    wait_row(n);
    i_row_eom = 1'b0;
    tick(2);
    chk({o_play, o_int_n}, 12'h000);
    chk(o_row_addr, {2'b00, p + 10'h001});
    send(mk(1'b1, 1'b1, 1'b0, 1'b1, LAST - 10'h003));
    tick(40);
    chk({o_play, o_int_n}, 12'h000);
    send(mk(1'b0, 1'b0, 1'b1, 1'b0, 10'h000));
    chk(st, {LAST, 2'b01});
    done("cue");
  endtask

  task automatic t_stop();
    send(mk(1'b1, 1'b0, 1'b0, 1'b0, 10'h100));
    chk(o_record, 12'h001);
    send(mk(1'b0, 1'b0, 1'b1, 1'b0, 10'h000));
    chk({o_record, o_play, o_int_n}, 12'h001);
    tick(100);
    send(16'h0000);
    chk({o_wake, o_ready}, 12'h000);
    // Start straight after wake-up must be refused until the delay runs out
    send(mk(1'b1, 1'b1, 1'b0, 1'b0, 10'h020));
    chk({o_wake, o_ready, o_play}, 12'h004);
    chk(o_row_addr, 12'h100);
    done("stop");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------------------
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    i_mclk = 1'b0;
    i_rstn = 1'b0;
    i_row_eom = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    tick(16);
    i_rstn = 1'b1;
    tick(2);
    t_reset();
    t_wake();
    t_play();
    t_eom();
    t_rec();
    t_cue();
    t_stop();
    close_out();
  end
endmodule
